// file: common/jrx_pkg.sv
// constants, tap states and the next-state function for the jtag core hold / extest block
//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] identification value carries an 11-bit maker code shifted out with it
// [R2] id word: version 31..28, part 27..12, maker 11..1, bit 0 fixed one
// [R3] a one in the hold stage keeps the core in reset like the reset pin
// [R4] after the hold stage clears, reset lasts a fuse-selected time-out
// [R5] hold stage has no update latch; its value acts on core reset at once
// [R6] opcode 0xc selects the one-bit hold stage; tap controller not reset
// [R7] instruction register is four bits, sixteen possible opcodes
// [R8] no float-all-outputs instruction; hold instruction floats outputs instead
// [R9] core held in reset returns every pin to tri-state; under extest the pins keep the latched chain values instead
// [R10] all shift registers move least significant bit first in and out
// [R11] opcode 0x0 puts the boundary chain between tdi and tdo
// [R12] each pin has pull-up disable, output control, output data, input cells
// [R13] chain also holds cells at the analog to digital interface
// [R14] extest drives latched chain outputs onto pins once loaded
// [R15] extest capture-dr samples the pin levels into the chain
// [R16] extest shift-dr moves the chain one cell per tck toward tdo
// [R17] extest update-dr copies the chain into the pin output latches
// [R18] tester preloads safe output values before loading extest
`default_nettype none

package jrx_pkg;

   // instruction register and opcodes
   localparam int         IR_W       = 4;
   localparam logic [3:0] OP_EXTEST  = 4'h0;
   localparam logic [3:0] OP_IDCODE  = 4'h1;
   localparam logic [3:0] OP_PRELOAD = 4'h2;
   localparam logic [3:0] OP_HOLD    = 4'hc;
   localparam logic [3:0] OP_BYPASS  = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // identification word layout
   localparam int ID_W      = 32;
   localparam int VER_LSB   = 28;
   localparam int VER_W     = 4;
   localparam int PART_LSB  = 12;
   localparam int PART_W    = 16;
   localparam int MAKER_LSB = 1;
   localparam int MAKER_W   = 11;
   localparam int ID_ONE    = 0;

   // boundary cells of one pin, lowest index nearest tdo
   localparam int CELL_IN   = 0;
   localparam int CELL_DO   = 1;
   localparam int CELL_OC   = 2;
   localparam int CELL_PUD  = 3;
   localparam int CELLS_PIN = 4;

   // time-out selection and default lengths in clk_in cycles
   localparam int          FUSE_W    = 2;
   localparam int          TOUT_W    = 16;
   localparam int unsigned TOUT_DEF0 = 16;
   localparam int unsigned TOUT_DEF1 = 256;
   localparam int unsigned TOUT_DEF2 = 4096;
   localparam int unsigned TOUT_DEF3 = 65535;

   // tap controller states, one-hot
   typedef enum logic [15:0] {
      TAP_TLR    = 16'h0001,
      TAP_RTI    = 16'h0002,
      TAP_SELDR  = 16'h0004,
      TAP_CAPDR  = 16'h0008,
      TAP_SHDR   = 16'h0010,
      TAP_EX1DR  = 16'h0020,
      TAP_PAUSDR = 16'h0040,
      TAP_EX2DR  = 16'h0080,
      TAP_UPDDR  = 16'h0100,
      TAP_SELIR  = 16'h0200,
      TAP_CAPIR  = 16'h0400,
      TAP_SHIR   = 16'h0800,
      TAP_EX1IR  = 16'h1000,
      TAP_PAUSIR = 16'h2000,
      TAP_EX2IR  = 16'h4000,
      TAP_UPDIR  = 16'h8000
   } jrx_tap_type;

   // standard tap walk on tms
   function automatic jrx_tap_type jrx_tap_next(input jrx_tap_type s, input logic tms);
      case (s)
         TAP_TLR:    jrx_tap_next = tms ? TAP_TLR   : TAP_RTI;
         TAP_RTI:    jrx_tap_next = tms ? TAP_SELDR : TAP_RTI;
         TAP_SELDR:  jrx_tap_next = tms ? TAP_SELIR : TAP_CAPDR;
         TAP_CAPDR:  jrx_tap_next = tms ? TAP_EX1DR : TAP_SHDR;
         TAP_SHDR:   jrx_tap_next = tms ? TAP_EX1DR : TAP_SHDR;
         TAP_EX1DR:  jrx_tap_next = tms ? TAP_UPDDR : TAP_PAUSDR;
         TAP_PAUSDR: jrx_tap_next = tms ? TAP_EX2DR : TAP_PAUSDR;
         TAP_EX2DR:  jrx_tap_next = tms ? TAP_UPDDR : TAP_SHDR;
         TAP_UPDDR:  jrx_tap_next = tms ? TAP_SELDR : TAP_RTI;
         TAP_SELIR:  jrx_tap_next = tms ? TAP_TLR   : TAP_CAPIR;
         TAP_CAPIR:  jrx_tap_next = tms ? TAP_EX1IR : TAP_SHIR;
         TAP_SHIR:   jrx_tap_next = tms ? TAP_EX1IR : TAP_SHIR;
         TAP_EX1IR:  jrx_tap_next = tms ? TAP_UPDIR : TAP_PAUSIR;
         TAP_PAUSIR: jrx_tap_next = tms ? TAP_EX2IR : TAP_PAUSIR;
         TAP_EX2IR:  jrx_tap_next = tms ? TAP_UPDIR : TAP_SHIR;
         TAP_UPDIR:  jrx_tap_next = tms ? TAP_SELDR : TAP_RTI;
         default:    jrx_tap_next = TAP_TLR;
      endcase
   endfunction : jrx_tap_next

endpackage : jrx_pkg

`default_nettype wire

// file: verilog/jrx_pin_cell.sv
// one pin's boundary cells: pad input filter, capture vector and pad output mux
`default_nettype none

module jrx_pin_cell (
   input  wire logic                              tck_in,
   input  wire logic                              rst_in,
   input  wire logic                              pad_in,
   input  wire logic                              core_o_in,
   input  wire logic                              core_oe_in,
   input  wire logic                              core_pud_in,
   input  wire logic [jrx_pkg::CELLS_PIN-1:0]     upd_in,
   input  wire logic                              extest_in,
   input  wire logic                              core_rst_in,
   output logic      [jrx_pkg::CELLS_PIN-1:0]     cap_out,
   output logic                                   pad_o_out,
   output logic                                   pad_oe_out,
   output logic                                   pull_en_out
);
   import jrx_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic filt;
   } jrx_pin_state_type;

   jrx_pin_state_type q, d;

   // three-stage pad sampler; level taken when stages two and three agree
   always_comb begin
      d      = q;
      d.s1   = pad_in;
      d.s2   = q.s1;
      d.s3   = q.s2;
      if (q.s2 == q.s3) begin
         d.filt = q.s3;
      end
      if (rst_in) begin
         d = '0;
      end
   end

   always_ff @(posedge tck_in) begin
      q <= d;
   end

   // values offered to the chain at capture-dr
   always_comb begin
      cap_out           = '0;
      cap_out[CELL_IN]  = q.filt;        // [R15]
      cap_out[CELL_DO]  = core_o_in;     // [R12]
      cap_out[CELL_OC]  = core_oe_in;
      cap_out[CELL_PUD] = core_pud_in;
   end

   // pad drive: latched chain under extest, else core unless held in reset
   always_comb begin
      if (extest_in) begin
         pad_o_out   = upd_in[CELL_DO];                       // [R14]
         pad_oe_out  = upd_in[CELL_OC];
         pull_en_out = ~upd_in[CELL_PUD] & ~upd_in[CELL_OC];
      end else if (core_rst_in) begin
         pad_o_out   = 1'b0;                                  // [R9]
         pad_oe_out  = 1'b0;
         pull_en_out = 1'b0;
      end else begin
         pad_o_out   = core_o_in;
         pad_oe_out  = core_oe_in;
         pull_en_out = ~core_pud_in & ~core_oe_in;
      end
   end

endmodule : jrx_pin_cell

`default_nettype wire

// file: verilog/jrx_tap_top.sv
// tap controller, identification, core hold stage and extest boundary chain
`default_nettype none

module jrx_tap_top #(
   parameter int          N_PINS    = 4,
   parameter int          N_ANA     = 1,
   parameter logic [3:0]  VERSION   = 4'h0,
   parameter logic [15:0] PART_CODE = 16'h5a5a,   // arbitrary value
   parameter logic [10:0] MAKER_ID  = 11'h2aa,    // arbitrary value
   parameter int unsigned TOUT0     = jrx_pkg::TOUT_DEF0,
   parameter int unsigned TOUT1     = jrx_pkg::TOUT_DEF1,
   parameter int unsigned TOUT2     = jrx_pkg::TOUT_DEF2,
   parameter int unsigned TOUT3     = jrx_pkg::TOUT_DEF3
) (
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   input  wire logic                          tck_in,
   input  wire logic                          tms_in,
   input  wire logic                          tdi_in,
   output logic                               tdo_out,
   output logic                               tdo_oe_out,
   input  wire logic                          ext_reset_n_in,
   input  wire logic [jrx_pkg::FUSE_W-1:0]    fuse_sel_in,
   output logic                               core_reset_out,
   input  wire logic [N_PINS-1:0]             pad_in,
   output logic      [N_PINS-1:0]             pad_o_out,
   output logic      [N_PINS-1:0]             pad_oe_out,
   output logic      [N_PINS-1:0]             pull_en_out,
   input  wire logic [N_PINS-1:0]             core_o_in,
   input  wire logic [N_PINS-1:0]             core_oe_in,
   input  wire logic [N_PINS-1:0]             core_pud_in,
   input  wire logic [N_ANA-1:0]              ana_in
);
   import jrx_pkg::*;

   localparam int CH = CELLS_PIN * N_PINS + N_ANA;

   //////////////////////////////////////////////////////////////////////////
   // tck domain state
   typedef struct packed {
      logic [1:0]      rsync;
      jrx_tap_type     st;
      logic [IR_W-1:0] ir;
      logic [IR_W-1:0] irsh;
      logic [CH-1:0]   chain;
      logic [CH-1:0]   upd;
      logic [ID_W-1:0] idsh;
      logic            byp;
      logic            hold;
      logic [N_ANA-1:0] a1;
      logic [N_ANA-1:0] a2;
      logic [N_ANA-1:0] a3;
      logic [N_ANA-1:0] af;
   } jrx_tck_type;

   // clk domain state
   typedef struct packed {
      logic [2:0]        hs;
      logic [2:0]        es;
      logic              held;
      logic              ext_low;
      logic [FUSE_W-1:0] f1;
      logic [FUSE_W-1:0] f2;
      logic [FUSE_W-1:0] f3;
      logic [FUSE_W-1:0] fsel;
      logic [TOUT_W-1:0] cnt;
   } jrx_clk_type;

   jrx_tck_type      tq, td;
   jrx_clk_type      cq, cd;
   logic             tck_rst;
   logic             extest;
   logic [CH-1:0]    cap_vec;
   logic [ID_W-1:0]  id_value;
   logic [TOUT_W-1:0] tout_load;

   assign tck_rst = tq.rsync[1];
   assign extest  = (tq.ir == OP_EXTEST);   // [R14]

   // identification word
   always_comb begin
      id_value                          = '0;
      id_value[VER_LSB   +: VER_W]      = VERSION;     // [R2]
      id_value[PART_LSB  +: PART_W]     = PART_CODE;
      id_value[MAKER_LSB +: MAKER_W]    = MAKER_ID;    // [R1]
      id_value[ID_ONE]                  = 1'b1;
   end

   //////////////////////////////////////////////////////////////////////////
   // per-pin cells and analog interface cells
   genvar gi;
   generate
      for (gi = 0; gi < N_PINS; gi++) begin : g_pin
         jrx_pin_cell u_cell (
            .tck_in      (tck_in),
            .rst_in      (tck_rst),
            .pad_in      (pad_in[gi]),
            .core_o_in   (core_o_in[gi]),
            .core_oe_in  (core_oe_in[gi]),
            .core_pud_in (core_pud_in[gi]),
            .upd_in      (tq.upd[gi*CELLS_PIN +: CELLS_PIN]),
            .extest_in   (extest),
            .core_rst_in (core_reset_out),
            .cap_out     (cap_vec[gi*CELLS_PIN +: CELLS_PIN]),
            .pad_o_out   (pad_o_out[gi]),
            .pad_oe_out  (pad_oe_out[gi]),
            .pull_en_out (pull_en_out[gi])
         );
      end
   endgenerate

   assign cap_vec[CH-1 -: N_ANA] = tq.af;   // [R13]

   //////////////////////////////////////////////////////////////////////////
   // tap controller and data registers
   always_comb begin
      td       = tq;
      td.rsync = {tq.rsync[0], rst_in};
      td.a1    = ana_in;
      td.a2    = tq.a1;
      td.a3    = tq.a2;
      td.af    = ((tq.a2 ~^ tq.a3) & tq.a3) | ((tq.a2 ^ tq.a3) & tq.af);
      case (tq.st)
         TAP_TLR: begin
            td.ir   = OP_IDCODE;
            td.hold = 1'b0;
         end
         TAP_CAPIR: begin
            td.irsh = IR_CAPTURE;
         end
         TAP_SHIR: begin
            td.irsh = {tdi_in, tq.irsh[IR_W-1:1]};           // [R10] [R7]
         end
         TAP_UPDIR: begin
            td.ir = tq.irsh;                                  // [R7]
         end
         TAP_CAPDR: begin
            case (tq.ir)
               OP_EXTEST, OP_PRELOAD: td.chain = cap_vec;     // [R15]
               OP_IDCODE:             td.idsh  = id_value;
               OP_HOLD:               td.hold  = tq.hold;
               default:               td.byp   = 1'b0;
            endcase
         end
         TAP_SHDR: begin
            case (tq.ir)
               OP_EXTEST, OP_PRELOAD: td.chain = {tdi_in, tq.chain[CH-1:1]};  // [R16] [R10] [R11]
               OP_IDCODE:             td.idsh  = {tdi_in, tq.idsh[ID_W-1:1]};
               OP_HOLD:               td.hold  = tdi_in;                     // [R6] [R5]
               default:               td.byp   = tdi_in;                     // [R8]
            endcase
         end
         TAP_UPDDR: begin
            if (tq.ir == OP_EXTEST || tq.ir == OP_PRELOAD) begin
               td.upd = tq.chain;                             // [R17]
            end
         end
         default: begin
            td.st = tq.st;
         end
      endcase
      td.st = jrx_tap_next(tq.st, tms_in);   // hold stage never touches the walk [R6]
      if (tck_rst) begin
         td       = '0;
         td.rsync = {tq.rsync[0], rst_in};
         td.st    = TAP_TLR;
         td.ir    = OP_IDCODE;
      end
   end

   always_ff @(posedge tck_in) begin
      tq <= td;
   end

   // tdo follows the selected register's lowest bit while shifting
   always_comb begin
      tdo_out    = 1'b0;
      tdo_oe_out = 1'b0;
      if (tq.st == TAP_SHIR) begin
         tdo_out    = tq.irsh[0];                             // [R10]
         tdo_oe_out = 1'b1;
      end else if (tq.st == TAP_SHDR) begin
         tdo_oe_out = 1'b1;
         case (tq.ir)
            OP_EXTEST, OP_PRELOAD: tdo_out = tq.chain[0];     // [R11]
            OP_IDCODE:             tdo_out = tq.idsh[0];
            OP_HOLD:               tdo_out = tq.hold;
            default:               tdo_out = tq.byp;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // clk domain: hold and pin reset sampling, fuse-selected time-out
   always_comb begin
      case (cq.fsel)
         2'h0:    tout_load = TOUT_W'(TOUT0);
         2'h1:    tout_load = TOUT_W'(TOUT1);
         2'h2:    tout_load = TOUT_W'(TOUT2);
         default: tout_load = TOUT_W'(TOUT3);
      endcase
   end

   always_comb begin
      cd    = cq;
      cd.hs = {cq.hs[1:0], tq.hold};
      cd.es = {cq.es[1:0], ~ext_reset_n_in};
      cd.f1 = fuse_sel_in;
      cd.f2 = cq.f1;
      cd.f3 = cq.f2;
      if (cq.hs[1] == cq.hs[2]) begin
         cd.held = cq.hs[2];
      end
      if (cq.es[1] == cq.es[2]) begin
         cd.ext_low = cq.es[2];
      end
      if (cq.f2 == cq.f3) begin
         cd.fsel = cq.f3;
      end
      if (cq.held || cq.ext_low) begin
         cd.cnt = tout_load;                                  // [R4]
      end else if (cq.cnt != '0) begin
         cd.cnt = cq.cnt - TOUT_W'(1);
      end
      if (rst_in) begin
         cd = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      cq <= cd;
   end

   // hold stage acts straight away, no update latch in the path
   assign core_reset_out = tq.hold | cq.held | cq.ext_low | (cq.cnt != '0);   // [R3] [R5] [R4]

   //////////////////////////////////////////////////////////////////////////
   // checks
   tlr_walk_a: assert property (@(posedge tck_in) disable iff (tck_rst)           // [R6]
      tms_in [*5] |=> tq.st == TAP_TLR)
      else $error("five tms highs did not reach test-logic-reset");

   ir_load_a: assert property (@(posedge tck_in) disable iff (tck_rst)            // [R7]
      tq.st == TAP_UPDIR |=> tq.ir == $past(tq.irsh))
      else $error("instruction not loaded at update-ir");

   id_word_a: assert property (@(posedge tck_in) disable iff (tck_rst)            // [R2]
      tq.st == TAP_CAPDR && tq.ir == OP_IDCODE
      |=> tq.idsh[ID_ONE] && tq.idsh[MAKER_LSB +: MAKER_W] == MAKER_ID)
      else $error("identification word malformed");

   chain_shift_a: assert property (@(posedge tck_in) disable iff (tck_rst)        // [R16]
      tq.st == TAP_SHDR && extest
      |=> tq.chain == {$past(tdi_in), $past(tq.chain[CH-1:1])})
      else $error("chain did not shift lsb first");

   pin_capture_a: assert property (@(posedge tck_in) disable iff (tck_rst)        // [R15]
      tq.st == TAP_CAPDR && extest |=> tq.chain == $past(cap_vec))
      else $error("pins not captured at capture-dr");

   chain_update_a: assert property (@(posedge tck_in) disable iff (tck_rst)       // [R17]
      tq.st == TAP_UPDDR && extest |=> tq.upd == $past(tq.chain))
      else $error("output latches not updated");

   extest_drive_a: assert property (@(posedge tck_in) disable iff (tck_rst)       // [R14]
      extest |-> pad_oe_out[0] == tq.upd[CELL_OC] && pad_o_out[0] == tq.upd[CELL_DO])
      else $error("extest not driving latched values");

   hold_now_a: assert property (@(posedge tck_in) disable iff (tck_rst)           // [R5]
      tq.st == TAP_SHDR && tq.ir == OP_HOLD |=> tq.hold == $past(tdi_in))
      else $error("hold stage did not take the shifted bit");

   timeout_load_a: assert property (@(posedge clk_in) disable iff (rst_in)        // [R4]
      $fell(cq.held) && !cq.ext_low |-> cq.cnt == $past(tout_load) ##1 core_reset_out)
      else $error("time-out not applied after hold release");

   tristate_a: assert property (@(posedge clk_in) disable iff (rst_in)            // [R9]
      core_reset_out && !extest |-> pad_oe_out == '0 && pull_en_out == '0)
      else $error("pins driven while core held in reset");

   cov_extest_upd_c: cover property (@(posedge tck_in) tq.st == TAP_UPDDR && extest);
   cov_hold_set_c: cover property (@(posedge tck_in) tq.ir == OP_HOLD && tq.st == TAP_SHDR && tdi_in);
   cov_id_read_c: cover property (@(posedge tck_in) tq.st == TAP_CAPDR && tq.ir == OP_IDCODE);
   cov_tout_end_c: cover property (@(posedge clk_in) $fell(core_reset_out));

endmodule : jrx_tap_top

`default_nettype wire

// file: tb/jrx_tester.sv
// tester model: drives tck, tms and tdi and samples tdo of the test port
`default_nettype none

module jrx_tester (
   output logic     tck_out,
   output logic     tms_out,
   output logic     tdi_out,
   input  wire logic tdo_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // tck stands low between frames
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end

   // one tck period, tdo taken just before the rising edge
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      tms_out = tms;
      tdi_out = tdi;
      #32;
      tdo = tdo_in;
      tck_out = 1'b1;
      #32;
      tck_out = 1'b0;
   endtask : step

   // walk to test-logic-reset, then park in run-test-idle
   task automatic reset_tap();
      logic d;
      repeat (8) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask : reset_tap

   // idle periods so the pad filters settle
   task automatic idle(input int n);
      logic d;
      repeat (n) step(1'b0, 1'b0, d);
   endtask : idle

   // one ir or dr scan from run-test-idle back to run-test-idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic d;
      dout = '0;
      step(1'b1, 1'b0, d);
      if (ir) step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
      step(1'b0, 1'b0, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], d); // lsb first in and out
         dout[i] = d;
      end
      step(1'b1, 1'b0, d);
      step(1'b0, 1'b0, d);
   endtask : scan

endmodule : jrx_tester

`default_nettype wire

// file: tb/jrx_tap_top_tb.sv
// self-checking bench for the core hold and extest test port block
`default_nettype none

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module jrx_tap_top_tb;
   import jrx_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int          NP    = 4;
   localparam int          CH    = 4 * NP + 1;
   localparam logic [3:0]  VER   = 4'h3;    // arbitrary value
   localparam logic [15:0] PARTC = 16'h1234; // arbitrary value
   localparam logic [10:0] MAKER = 11'h155;  // arbitrary value

   logic          clk_in = 1'b0;
   logic          rst_in;
   logic          ext_n;
   logic [1:0]    fuse;
   logic [NP-1:0] core_o, core_oe, core_pud, pad_ext, pad_o, pad_oe, pull_en;
   wire  [NP-1:0] pad_lvl;
   logic          ana, tdo, tdo_oe, core_rst;
   wire           tck, tms, tdi;
   logic [31:0]   got;
   int            mismatches = 0;
   int            samples_checked = 0;

   // clock and pin wire level: driven pins show the design, others the board level
   always #12.5 clk_in = ~clk_in;
   assign pad_lvl = (pad_oe & pad_o) | (~pad_oe & pad_ext);

   jrx_tap_top #(.N_PINS(NP), .N_ANA(1), .VERSION(VER), .PART_CODE(PARTC), .MAKER_ID(MAKER),
      .TOUT0(4), .TOUT1(8), .TOUT2(12), .TOUT3(16)) dut_u (
      .clk_in(clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
      .tdo_oe_out(tdo_oe), .ext_reset_n_in(ext_n), .fuse_sel_in(fuse), .core_reset_out(core_rst),
      .pad_in(pad_lvl), .pad_o_out(pad_o), .pad_oe_out(pad_oe), .pull_en_out(pull_en),
      .core_o_in(core_o), .core_oe_in(core_oe), .core_pud_in(core_pud), .ana_in(ana));

   jrx_tester tester_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));

   ////////////////////////////////////////////////////////////////////////////////
   // chain image: per pin input, output data, output control, pull-up disable
   function automatic logic [31:0] chain(input logic [NP-1:0] i, o, c, p, input logic a);
      logic [31:0] v;
      v = '0;
      for (int k = 0; k < NP; k++) v[4*k +: 4] = {p[k], c[k], o[k], i[k]};
      v[CH-1] = a;
      return v;
   endfunction : chain

   // wait for core reset to drop, bounded by lim clk cycles
   task automatic wait_low(input int lim);
      int n;
      n = 0;
      while (core_rst === 1'b1 && n < lim) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      `CHK("core reset released", 1'b0, core_rst)
   endtask : wait_low

   task automatic t_ident();
      tester_u.scan(1'b1, IR_W, {28'h0, OP_IDCODE}, got);
      `CHK("ir capture", 32'h1, got)
      `CHK("tdo idle", 1'b0, tdo_oe)
      tester_u.scan(1'b0, ID_W, 32'h0, got);
      `CHK("id word", {VER, PARTC, MAKER, 1'b1}, got)
   endtask : t_ident

   task automatic t_hold();
      tester_u.scan(1'b1, IR_W, {28'h0, OP_HOLD}, got);
      tester_u.scan(1'b0, 1, 32'h1, got);
      `CHK("hold sets reset", 1'b1, core_rst)
      `CHK("pins float", 4'h0, pad_oe | pull_en)
      tester_u.scan(1'b0, 1, 32'h0, got);
      `CHK("hold stage kept", 32'h1, got)
      repeat (8) @(posedge clk_in);
      #1;
      `CHK("time-out running", 1'b1, core_rst)
      wait_low(60);
      @(posedge clk_in) begin
         ext_n <= 1'b0;
         fuse  <= 2'd0;
      end
      repeat (6) @(posedge clk_in);
      #1;
      `CHK("reset pin low", 1'b1, core_rst)
      @(posedge clk_in) ext_n <= 1'b1;
      wait_low(12); // shortest fuse choice ends well before the longest one would
   endtask : t_hold

   task automatic t_bypass();
      tester_u.scan(1'b1, IR_W, 32'h7, got);
      tester_u.scan(1'b0, 2, 32'h3, got);
      `CHK("unknown opcode bypass", 32'h2, got)
      `CHK("pins follow core", core_oe, pad_oe)
      @(posedge clk_in) begin
         core_o   <= 4'b1001;
         core_oe  <= 4'b0110;
         core_pud <= 4'b0011;
      end
      #1;
      `CHK("core data out", 4'b1001, pad_o)
      `CHK("core enable out", 4'b0110, pad_oe)
      `CHK("core pull out", 4'b1000, pull_en)
   endtask : t_bypass

   task automatic t_extest();
      tester_u.scan(1'b1, IR_W, {28'h0, OP_PRELOAD}, got); // safe values first
      tester_u.scan(1'b0, CH, chain(4'h0, 4'b0101, 4'hf, 4'hf, 1'b0), got);
      `CHK("preload leaves pins", core_o, pad_o)
      tester_u.scan(1'b1, IR_W, {28'h0, OP_EXTEST}, got);
      `CHK("latched data driven", 4'b0101, pad_o)
      `CHK("latched enable driven", 4'hf, pad_oe)
      tester_u.idle(4);
      tester_u.scan(1'b0, CH, chain(4'h0, 4'b1010, 4'b1100, 4'b0101, 1'b0), got);
      `CHK("capture", chain(4'b0101, core_o, core_oe, core_pud, 1'b1), got)
      `CHK("update data", 4'b1010, pad_o)
      `CHK("update enable", 4'b1100, pad_oe)
      `CHK("update pull", 4'b0010, pull_en)
      @(posedge clk_in) ana <= 1'b0;
      tester_u.idle(4);
      tester_u.scan(1'b0, CH, chain(4'h0, 4'b1010, 4'b1100, 4'b0101, 1'b0), got);
      `CHK("capture pin mix", chain(4'b1000, core_o, core_oe, core_pud, 1'b0), got)
   endtask : t_extest

   task automatic give_verdict();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset both domains, then the scenarios
   initial begin
      rst_in = 1'b1;
      ext_n = 1'b1;
      fuse = 2'd3;
      core_o = 4'b0110;
      core_oe = 4'b0011;
      core_pud = 4'b1001;
      pad_ext = 4'b1100;
      ana = 1'b1;
      fork
         tester_u.reset_tap();
         begin
            repeat (10) @(posedge clk_in);
            rst_in <= 1'b0;
         end
      join
      t_ident();
      t_hold();
      t_bypass();
      t_extest();
      give_verdict();
   end

   // watchdog well beyond the expected run
   initial begin
      #100us;
      mismatches++;
      give_verdict();
   end

endmodule : jrx_tap_top_tb

`default_nettype wire
